// file: core_ops.sv
// Decode and execute core for the clear, complement, decrement and branch group
// ------------------------------------------------------------------
// Functional notes
// [RULE1] The clear-accumulator word loads zero into the accumulator and sets zero, in one cycle.
// [RULE2] Clearing the watchdog zeroes its counter and sets the timeout and powerdown flags to one.
// [RULE3] Clearing the watchdog clears the prescaler only while it is assigned to the watchdog.
// [RULE4] The complement op writes the inverted file register to the destination and updates zero.
// [RULE5] Destination bit 0 sends the result to the accumulator, 1 back to the file register.
// [RULE6] The decrement op writes file minus one to the destination and updates zero in one cycle.
// [RULE7] The decrement-skip op writes file minus one to the destination and leaves status alone.
// [RULE8] A zero decrement-skip result discards the prefetched word so the op takes two cycles.
// [RULE9] The branch loads its nine-bit immediate into program counter bits 8 to 0.
// [RULE10] The branch takes program counter bits 10 and 9 from status page bits 6 and 5.
// [RULE11] The branch always takes two cycles, the prefetched word being flushed.
// [RULE12] An updated zero flag is set for an all-zero eight-bit result and cleared otherwise.
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module core_ops #(
  parameter int unsigned FILE_REGS = core_ops_pkg::FILE_DEPTH // Number of file registers
) (
  input wire logic aclk, // 40 MHz clock
  input wire logic aresetn, // Synchronous reset
  input wire logic [core_ops_pkg::INSTR_W-1:0] instr_word, // Prefetched word
  input wire logic watchdog_tick, // Watchdog clock tick
  input wire logic prescaler_to_watchdog, // Prescaler assignment
  output var core_ops_pkg::fetch_t fetch_q, // Fetch address and enable
  output var core_ops_pkg::watchdog_t watchdog_q, // Watchdog state
  input wire logic [core_ops_pkg::AXI_ADDR_W-1:0] awaddr, // Write address
  input wire logic [2:0] awprot, // Unused
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [core_ops_pkg::AXI_DATA_W-1:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [core_ops_pkg::AXI_ADDR_W-1:0] araddr, // Read address
  input wire logic [2:0] arprot, // Unused
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [core_ops_pkg::AXI_DATA_W-1:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready // Read data ready
);
  import core_ops_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == '0);
  endfunction : is_zero

  function automatic logic addr_mapped(input logic [AXI_ADDR_W-1:0] a);
    addr_mapped = (a == CTRL_OFS) || (a == ACC_OFS) || (a == STATUS_OFS) ||
                  (a == WDT_OFS) || (a == PC_OFS) ||
                  (a[FILE_SEL_BIT] && (a[1:0] == 2'b00) &&
                   (32'(a[6:2]) < FILE_REGS));
  endfunction : addr_mapped

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] file_q [FILE_REGS];
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [DATA_W-1:0] presc_q;
  logic [DATA_W-1:0] presc_d;
  logic [DATA_W-1:0] wdt_d;
  logic flush_q;
  logic [PC_W-1:0] pc_d;
  logic aw_held_q;
  logic w_held_q;
  logic [AXI_ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;
  logic wr_strb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [AXI_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic [AXI_DATA_W-1:0] rd_mux;
  logic rd_err;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic exec = fetch_q.enable & ~flush_q;
  wire logic op_clr_acc = (instr_word == CLR_ACC_WORD);
  wire logic op_clr_wdt = (instr_word == CLR_WDT_WORD);
  wire logic op_comp = (instr_word[11:6] == COMP_PREFIX);
  wire logic op_dec = (instr_word[11:6] == DEC_PREFIX);
  wire logic op_dskip = (instr_word[11:6] == DEC_SKIP_PREFIX);
  wire logic op_branch = (instr_word[11:9] == BRANCH_PREFIX);
  wire logic reg_op = op_comp | op_dec | op_dskip;
  wire logic to_file = instr_word[DEST_BIT];
  wire logic [FILE_ADDR_W-1:0] f_addr = instr_word[FILE_ADDR_W-1:0];
  wire logic [DATA_W-1:0] file_rd = file_q[f_addr];
  wire logic [DATA_W-1:0] alu_res = op_comp ? ~file_rd : file_rd - 8'h01; // RULE4 RULE6 RULE7
  wire logic res_zero = is_zero(alu_res);
  wire logic core_clr_acc = exec & op_clr_acc;
  wire logic core_clr_wdt = exec & op_clr_wdt;
  wire logic core_acc_wr = exec & reg_op & ~to_file; // RULE5
  wire logic core_file_wr = exec & reg_op & to_file; // RULE5
  wire logic core_branch = exec & op_branch;
  wire logic skip_next = exec & op_dskip & res_zero; // RULE8
  wire logic wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire logic wr_ok = wr_fire & wr_strb0_q & addr_mapped(wr_addr_q);
  wire logic wr_ctrl = wr_ok & (wr_addr_q == CTRL_OFS);
  wire logic wr_acc = wr_ok & (wr_addr_q == ACC_OFS);
  wire logic wr_status = wr_ok & (wr_addr_q == STATUS_OFS);
  wire logic wr_file = wr_ok & wr_addr_q[FILE_SEL_BIT];
  wire logic [FILE_ADDR_W-1:0] wr_file_idx = wr_addr_q[6:2];
  wire logic aw_take = awvalid & awready;
  wire logic w_take = wvalid & wready;
  wire logic ar_take = arvalid & arready_q;
  wire logic [FILE_ADDR_W-1:0] rd_file_idx = araddr[6:2];

  // ----------------------------------------------------------------
  // Program counter and flush
  // ----------------------------------------------------------------
  always_comb begin
    if (core_branch) begin
      pc_d = {status_q[PAGE_HI:PAGE_LO], instr_word[BRANCH_K_W-1:0]}; // RULE9 RULE10
    end else if (fetch_q.enable) begin
      pc_d = fetch_q.addr + 11'h001;
    end else begin
      pc_d = fetch_q.addr;
    end
  end

  // Reset flushes the first word, which memory has not yet fetched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_q <= '{addr: PC_RESET, enable: 1'b0};
      flush_q <= 1'b1;
    end else begin
      fetch_q.addr <= pc_d;
      if (wr_ctrl) begin
        fetch_q.enable <= wr_data_q[CTRL_RUN_BIT];
      end
      if (fetch_q.enable) begin
        flush_q <= core_branch | skip_next; // RULE8 RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and file registers; core writes win over the bus
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= ACC_RESET;
    end else if (core_clr_acc) begin
      acc_q <= ACC_RESET; // RULE1
    end else if (core_acc_wr) begin
      acc_q <= alu_res; // RULE5
    end else if (wr_acc) begin
      acc_q <= wr_data_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < FILE_REGS; i++) begin
        file_q[i] <= '0;
      end
    end else if (core_file_wr) begin
      file_q[f_addr] <= alu_res; // RULE5
    end else if (wr_file) begin
      file_q[wr_file_idx] <= wr_data_q;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = (status_q & ~STATUS_WR_MASK) | (wr_data_q & STATUS_WR_MASK);
    end
    if (core_clr_acc) begin
      status_d[ZERO_BIT] = 1'b1; // RULE1
    end
    if (exec & (op_comp | op_dec)) begin
      status_d[ZERO_BIT] = res_zero; // RULE4 RULE6 RULE12
    end
    if (core_clr_wdt) begin
      status_d[TIMEOUT_BIT] = 1'b1; // RULE2
      status_d[POWERDOWN_BIT] = 1'b1; // RULE2
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter and prescaler; a clear beats a coincident tick
  // ----------------------------------------------------------------
  wire logic presc_wrap = prescaler_to_watchdog & (presc_q == PRESCALER_WRAP);
  wire logic wdt_step = watchdog_tick & (~prescaler_to_watchdog | presc_wrap);

  always_comb begin
    presc_d = presc_q;
    wdt_d = watchdog_q.counter;
    if (watchdog_tick & prescaler_to_watchdog) begin
      presc_d = presc_q + 8'h01;
    end
    if (wdt_step) begin
      wdt_d = watchdog_q.counter + 8'h01;
    end
    if (core_clr_wdt) begin
      wdt_d = WDT_CLEAR_VALUE; // RULE2
      if (prescaler_to_watchdog) begin
        presc_d = PRESCALER_CLEAR_VALUE; // RULE3
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= PRESCALER_CLEAR_VALUE;
      watchdog_q <= '{clear: 1'b0, prescaler_clear: 1'b0, counter: WDT_CLEAR_VALUE};
    end else begin
      presc_q <= presc_d;
      watchdog_q.counter <= wdt_d;
      watchdog_q.clear <= core_clr_wdt;
      watchdog_q.prescaler_clear <= core_clr_wdt & prescaler_to_watchdog; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // Register bus: write side
  // ----------------------------------------------------------------
  assign awready = ~aw_held_q & ~bvalid_q;
  assign wready = ~w_held_q & ~bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        wr_addr_q <= awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wr_data_q <= wdata[DATA_W-1:0];
        wr_strb0_q <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_mapped(wr_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q & bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus: read side
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (!addr_mapped(araddr)) begin
      rd_err = 1'b1;
    end else if (araddr == CTRL_OFS) begin
      rd_mux[CTRL_RUN_BIT] = fetch_q.enable;
    end else if (araddr == ACC_OFS) begin
      rd_mux[DATA_W-1:0] = acc_q;
    end else if (araddr == STATUS_OFS) begin
      rd_mux[DATA_W-1:0] = status_q;
    end else if (araddr == WDT_OFS) begin
      rd_mux[2*DATA_W-1:0] = {presc_q, watchdog_q.counter};
    end else if (araddr == PC_OFS) begin
      rd_mux[PC_W-1:0] = fetch_q.addr;
    end else begin
      rd_mux[DATA_W-1:0] = file_q[rd_file_idx];
    end
  end

  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q & rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  clear_acc_a: assert property (core_clr_acc |=> (acc_q == 8'h00) && status_q[ZERO_BIT]) // RULE1
    else $error("accumulator clear left a value or the zero flag wrong");
  wdt_clear_a: assert property (core_clr_wdt |=> watchdog_q.counter == 8'h00 // RULE2
      && watchdog_q.clear && status_q[TIMEOUT_BIT] && status_q[POWERDOWN_BIT])
    else $error("watchdog clear left counter or flags wrong");
  presc_kept_a: assert property (core_clr_wdt && !prescaler_to_watchdog // RULE3
      |=> presc_q == $past(presc_q) && !watchdog_q.prescaler_clear)
    else $error("prescaler touched while assigned to timer");
  presc_cleared_a: assert property (core_clr_wdt && prescaler_to_watchdog // RULE3
      |=> presc_q == 8'h00) else $error("prescaler not cleared while assigned to watchdog");
  comp_to_acc_a: assert property (exec && op_comp && !to_file // RULE4
      |=> acc_q == ~$past(file_rd) && status_q[ZERO_BIT] == ($past(file_rd) == 8'hff))
    else $error("complement result or zero flag wrong");
  dest_file_a: assert property (core_file_wr |=> file_q[$past(f_addr)] == $past(alu_res) // RULE5
      && acc_q == $past(acc_q))
    else $error("file destination write wrong or accumulator disturbed");
  dec_zero_a: assert property (exec && op_dec // RULE6
      |=> status_q[ZERO_BIT] == ($past(file_rd) == 8'h01))
    else $error("decrement zero flag wrong");
  skip_status_a: assert property (exec && op_dskip && !wr_status |=> $stable(status_q)) // RULE7
    else $error("decrement-skip changed status");
  skip_two_a: assert property (skip_next && !wr_ctrl |=> !exec // RULE8
      ##1 (exec || !fetch_q.enable)) else $error("decrement-skip did not take two cycles");
  nonzero_noskip_a: assert property (exec && op_dskip && !res_zero |=> !flush_q) // RULE8
    else $error("nonzero decrement-skip flushed the next word");
  branch_target_a: assert property (core_branch // RULE9 RULE10
      |=> fetch_q.addr == {$past(status_q[PAGE_HI:PAGE_LO]), $past(instr_word[8:0])})
    else $error("branch target wrong");
  branch_flush_a: assert property (core_branch && !wr_ctrl |=> !exec // RULE11
      ##1 (exec || !fetch_q.enable)) else $error("branch did not take two cycles");

endmodule : core_ops

`default_nettype wire

// file: core_ops_pkg.sv
// Constants, field layouts and carrier types for the instruction group core
package core_ops_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FILE_ADDR_W = 5;
  localparam int unsigned FILE_DEPTH = 32;
  localparam int unsigned PC_W = 11;
  localparam int unsigned INSTR_W = 12;
  localparam int unsigned BRANCH_K_W = 9;
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // ----------------------------------------------------------------
  // Instruction encodings and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] CLR_ACC_WORD = 12'h040;
  localparam logic [11:0] CLR_WDT_WORD = 12'h004;
  localparam logic [5:0] COMP_PREFIX = 6'h09;
  localparam logic [5:0] DEC_PREFIX = 6'h03;
  localparam logic [5:0] DEC_SKIP_PREFIX = 6'h0b;
  localparam logic [2:0] BRANCH_PREFIX = 3'h5;
  localparam int unsigned DEST_BIT = 5;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int unsigned PAGE_HI = 6;
  localparam int unsigned PAGE_LO = 5;
  localparam int unsigned TIMEOUT_BIT = 4;
  localparam int unsigned POWERDOWN_BIT = 3;
  localparam int unsigned ZERO_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] STATUS_WR_MASK = 8'h64;

  // ----------------------------------------------------------------
  // Reset and clear values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDT_CLEAR_VALUE = 8'h00;
  localparam logic [7:0] PRESCALER_CLEAR_VALUE = 8'h00;
  localparam logic [7:0] PRESCALER_WRAP = 8'hff;
  localparam logic [10:0] PC_RESET = 11'h000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ACC_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] WDT_OFS = 8'h0c;
  localparam logic [7:0] PC_OFS = 8'h10;
  localparam int unsigned FILE_SEL_BIT = 7;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic enable;
  } fetch_t;

  typedef struct packed {
    logic clear;
    logic prescaler_clear;
    logic [DATA_W-1:0] counter;
  } watchdog_t;

endpackage : core_ops_pkg

// file: prog_mem.sv
// Program memory model that feeds twelve-bit instruction words to the core
`timescale 1ns/1ps
`default_nettype none

module prog_mem (
  input wire core_ops_pkg::fetch_t fetch, // Fetch address and enable
  input wire logic aclk, // Core clock
  output logic [core_ops_pkg::INSTR_W-1:0] instr_word // Word to the core
);
  import core_ops_pkg::*;

  logic [INSTR_W-1:0] mem [0:(1 << PC_W)-1];

  initial instr_word = 12'h000;

  // Holds its word while fetching is off, like a stalled memory
  always @(posedge aclk) begin
    if (fetch.enable) begin
      instr_word <= mem[fetch.addr];
    end
  end
endmodule : prog_mem

`default_nettype wire

// file: test_clear_complement_decrement_branch_ops.sv
// Self-checking bench for the clear, complement, decrement and branch core
`timescale 1ns/1ps
`default_nettype none

module test_clear_complement_decrement_branch_ops;
  import core_ops_pkg::*;

  logic aclk, aresetn, watchdog_tick, prescaler_to_watchdog;
  logic [INSTR_W-1:0] instr_word;
  fetch_t fetch_q;
  watchdog_t watchdog_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int n_checks = 0;

  core_ops i_core_ops (.aclk(aclk), .aresetn(aresetn), .instr_word(instr_word),
    .watchdog_tick(watchdog_tick), .prescaler_to_watchdog(prescaler_to_watchdog),
    .fetch_q(fetch_q), .watchdog_q(watchdog_q), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  prog_mem i_prog_mem (.fetch(fetch_q), .aclk(aclk), .instr_word(instr_word));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic hang(input string what);
    num_errors++;
    $display("mismatch at %0t ns: %s timed out", $time, what);
    tally_and_finish();
  endtask : hang

  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  // Handshakes are judged at the falling edge; nothing moves before the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check(r, RESP_OKAY, $sformatf("write response at %h", a));
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, exp, $sformatf("read data at %h", a));
    check(r, RESP_OKAY, $sformatf("read response at %h", a));
  endtask : rd_chk

  function automatic logic [7:0] fa(input int n);
    return 8'h80 + 8'(4 * n);
  endfunction : fa

  // Memory is refilled only after reset, when fetching is off
  task automatic restart();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < (1 << PC_W); i++) i_prog_mem.mem[i] = 12'h000;
  endtask : restart

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      watchdog_tick <= 1'b1;
      @(posedge aclk);
      watchdog_tick <= 1'b0;
    end
  endtask : tick

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic arith_case();
    logic [31:0] d;
    logic [1:0] r;
    restart();
    i_prog_mem.mem[0] = 12'h264;
    i_prog_mem.mem[1] = 12'h0e3;
    i_prog_mem.mem[2] = 12'h243;
    i_prog_mem.mem[3] = 12'ha03;
    wr(fa(3), 32'h13);
    wr(fa(4), 32'hff);
    axi_wr(8'h40, 32'h1, r);
    check(r, RESP_SLVERR, "unmapped write response");
    axi_rd(8'h44, d, r);
    check(r, RESP_SLVERR, "unmapped read response");
    check(d, 32'h0, "unmapped read data");
    wr(CTRL_OFS, 32'h1);
    repeat (12) @(posedge aclk);
    rd_chk(ACC_OFS, 32'hed);
    rd_chk(fa(3), 32'h12);
    rd_chk(fa(4), 32'h00);
    rd_chk(STATUS_OFS, 32'h18);
    rd_chk(CTRL_OFS, 32'h1);
    $display("test arith_case done");
  endtask : arith_case

  task automatic skip_branch_case();
    logic [31:0] d;
    logic [1:0] r;
    restart();
    i_prog_mem.mem[0] = 12'h2e6;
    i_prog_mem.mem[1] = 12'h2c5;
    i_prog_mem.mem[2] = 12'h266;
    i_prog_mem.mem[3] = 12'hb05;
    i_prog_mem.mem[4] = 12'h266;
    i_prog_mem.mem[11'h305] = 12'h2c7;
    i_prog_mem.mem[11'h306] = 12'hb06;
    wr(STATUS_OFS, 32'h20);
    wr(fa(5), 32'h01);
    wr(fa(6), 32'h03);
    wr(fa(7), 32'h09);
    wr(CTRL_OFS, 32'h1);
    repeat (20) @(posedge aclk);
    rd_chk(fa(6), 32'h02);
    rd_chk(fa(5), 32'h01);
    rd_chk(ACC_OFS, 32'h08);
    rd_chk(STATUS_OFS, 32'h38);
    axi_rd(PC_OFS, d, r);
    check(d >> 1, 32'h183, "branch loop address");
    check(r, RESP_OKAY, "branch loop address response");
    $display("test skip_branch_case done");
  endtask : skip_branch_case

  // Prescaler first counts for the watchdog, then is handed over as asked
  task automatic watchdog_case(input logic assign_bit);
    restart();
    i_prog_mem.mem[0] = 12'h004;
    i_prog_mem.mem[1] = 12'h040;
    i_prog_mem.mem[2] = 12'ha02;
    wr(ACC_OFS, 32'h5a);
    prescaler_to_watchdog <= 1'b1;
    tick(3);
    prescaler_to_watchdog <= assign_bit;
    tick(253);
    rd_chk(WDT_OFS, assign_bit ? 32'h0001 : 32'h03fd);
    wr(CTRL_OFS, 32'h1);
    for (int n = 0; n < 20; n++) begin
      @(negedge aclk);
      if (watchdog_q.clear === 1'b1) break;
    end
    if (watchdog_q.clear !== 1'b1) hang("watchdog clear pulse");
    check(watchdog_q.clear, 32'h1, "watchdog clear pulse");
    check(watchdog_q.prescaler_clear, assign_bit, "prescaler clear pulse");
    repeat (5) @(posedge aclk);
    rd_chk(WDT_OFS, assign_bit ? 32'h0 : 32'h0300);
    rd_chk(ACC_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'h1c);
    $display("test watchdog_case %0b done", assign_bit);
  endtask : watchdog_case

  initial begin
    aresetn = 1'b0;
    watchdog_tick = 1'b0;
    prescaler_to_watchdog = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    arith_case();
    skip_branch_case();
    watchdog_case(1'b1);
    watchdog_case(1'b0);
    tally_and_finish();
  end
endmodule : test_clear_complement_decrement_branch_ops

`default_nettype wire
